// ===== common/dce_pkg.sv
package dce_pkg;

	// ---------------------------------------------------------------
	// command opcodes and zones
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_REVISION_QUERY  = 8'h30;
	localparam logic [7:0] OP_DIGEST_GENERATE = 8'h15;
	localparam logic [7:0] OP_KEYED_HASH      = 8'h11;
	localparam logic [7:0] ZONE_CONFIG        = 8'h00;
	localparam logic [7:0] ZONE_OTP           = 8'h01;
	localparam logic [7:0] ZONE_DATA          = 8'h02;
	localparam logic [1:0] MEM_ZONE_CONFIG    = 2'h0;
	localparam logic [1:0] MEM_ZONE_OTP       = 2'h1;
	localparam logic [1:0] MEM_ZONE_DATA      = 2'h2;
	localparam logic [1:0] MEM_ZONE_TRANSPORT = 2'h3;
	localparam logic [15:0] TRANSPORT_BASE    = 16'h8000;
	localparam logic [15:0] SLOT_TAG_MAX      = 16'h000f;
	localparam logic [15:0] BLOCK_SEL_MAX     = 16'h0001;

	// ---------------------------------------------------------------
	// result codes, lengths, hmac pads
	// ---------------------------------------------------------------
	localparam logic [7:0] RES_OK        = 8'h00;
	localparam logic [7:0] RES_PARSE_ERR = 8'h03;
	localparam logic [7:0] RES_EXEC_ERR  = 8'h0f;
	localparam logic [5:0] LEN_STATUS    = 6'h01;
	localparam logic [5:0] LEN_REVISION  = 6'h04;
	localparam logic [5:0] LEN_DIGEST    = 6'h20;
	localparam logic [5:0] LEN_EXTRA     = 6'h04;
	localparam logic [7:0] IPAD          = 8'h36;
	localparam logic [7:0] OPAD          = 8'h5c;
	localparam logic [7:0] KEY_BLOCK_LEN = 8'h40;
	localparam logic [7:0] TOTAL_SHORT   = 8'h60;
	localparam logic [7:0] TOTAL_INNER   = 8'h98;
	// keyed-hash mode bits
	localparam int MODE_NONCE  = 2;
	localparam int MODE_OTP88  = 4;
	localparam int MODE_OTP64  = 5;
	localparam int MODE_SERIAL = 6;
	localparam logic [7:0] MODE_ZERO_MASK = 8'h8b;

	// ---------------------------------------------------------------
	// register map and fields
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_CTRL    = 8'h04;
	localparam logic [7:0] REG_DIGEST0 = 8'h08;
	localparam int CTRL_SET_VALID   = 0;
	localparam int CTRL_NONCE_FLAG  = 1;
	localparam int CTRL_CLR_VALID   = 2;
	localparam int STAT_VALID       = 0;
	localparam int STAT_DATA_ORIGIN = 1;
	localparam int STAT_NONCE       = 2;
	localparam int STAT_BUSY        = 3;
	localparam int STAT_TAG_LSB     = 4;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_INIT,
		ST_STREAM,
		ST_FINAL,
		ST_WAIT
	} dce_state_t;

endpackage

// ===== core/dce_engine.sv
`timescale 1ns/1ps
module dce_engine #(
	parameter logic [31:0] REV_WORD = 32'h00000001, // arbitrary value
	parameter int          ADDR_W   = 8
) (
	// clock and reset
	input  wire logic                 CLK_SYS_I,
	input  wire logic                 RST_I,
	input  wire logic                 CE_I,
	// register port
	input  wire logic [ADDR_W-1:0]    ADDR_I,
	input  wire logic [31:0]          WDATA_I,
	input  wire logic                 WR_I,
	input  wire logic                 RD_I,
	output logic      [31:0]          RDATA_O,
	// command in
	input  wire logic                 CMD_VALID_I,
	output logic                      CMD_READY_O,
	input  wire logic [7:0]           CMD_OPCODE_I,
	input  wire logic [7:0]           CMD_PARAM1_I,
	input  wire logic [15:0]          CMD_PARAM2_I,
	input  wire logic [31:0]          CMD_DATA_I,
	input  wire logic [5:0]           CMD_DATA_LEN_I,
	// result out
	output logic                      RESP_VALID_O,
	output logic                      RESP_ERROR_O,
	output logic      [5:0]           RESP_LEN_O,
	output logic      [255:0]         RESP_DATA_O,
	// stored data and device state
	output logic                      MEM_REQ_O,
	output logic      [1:0]           MEM_ZONE_O,
	output logic      [15:0]          MEM_INDEX_O,
	input  wire logic                 MEM_ACK_I,
	input  wire logic [255:0]         MEM_DATA_I,
	input  wire logic [15:0]          SLOT_VERIFY_ONLY_I,
	input  wire logic                 CFG_LOCKED_I,
	input  wire logic [71:0]          SERIAL_I,
	input  wire logic [87:0]          OTP_HEAD_I,
	// hash core
	output logic                      HASH_INIT_O,
	output logic                      HASH_VALID_O,
	output logic      [7:0]           HASH_BYTE_O,
	input  wire logic                 HASH_READY_I,
	output logic                      HASH_FINAL_O,
	input  wire logic                 HASH_DONE_I,
	input  wire logic [255:0]         HASH_DIGEST_I
);

	initial begin
		if (ADDR_W < 6) $error("ADDR_W too small for register map");
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		dce_pkg::dce_state_t st;
		logic [7:0]          op;
		logic [7:0]          p1;
		logic [15:0]         p2;
		logic [31:0]         extra;
		logic                vo;
		logic                keyed;
		logic                outer;
		logic [255:0]        key;
		logic [255:0]        scratch;
		logic [255:0]        inner;
		logic [7:0]          cnt;
		logic                valid;
		logic                data_origin;
		logic                nonce_origin;
		logic [3:0]          slot_tag;
		logic [31:0]         rdata;
		logic                resp_valid;
		logic                resp_err;
		logic [5:0]          resp_len;
		logic [255:0]        resp_data;
	} dce_regs_t;

	dce_regs_t state_reg;
	dce_regs_t state_next;

	// byte-order helpers: byte 0 ends up most significant
	function automatic logic [71:0] dce_rev72(input logic [71:0] v);
		logic [71:0] o;
		o = '0;
		for (int i = 0; i < 9; i++) begin
			o[71-8*i -: 8] = v[8*i +: 8];
		end
		return o;
	endfunction

	function automatic logic [87:0] dce_rev88(input logic [87:0] v);
		logic [87:0] o;
		o = '0;
		for (int i = 0; i < 11; i++) begin
			o[87-8*i -: 8] = v[8*i +: 8];
		end
		return o;
	endfunction

	// ---------------------------------------------------------------
	// message assembly
	// ---------------------------------------------------------------
	logic [71:0]  sn;
	logic [87:0]  otp;
	logic [63:0]  otp_lo;
	logic [23:0]  otp_hi;
	logic [31:0]  sn_mid;
	logic [15:0]  sn_hi;
	logic [31:0]  gd_params;
	logic [767:0] msg_vec;
	logic [511:0] key_vec;
	logic [7:0]   total;
	logic [7:0]   midx;
	logic         in_key;

	assign sn  = dce_rev72(SERIAL_I);
	assign otp = dce_rev88(OTP_HEAD_I);
	// bit 4 overrides bit 5
	assign otp_lo = (state_reg.p1[dce_pkg::MODE_OTP88] || state_reg.p1[dce_pkg::MODE_OTP64])
		? otp[87:24] : 64'h0;
	assign otp_hi = state_reg.p1[dce_pkg::MODE_OTP88] ? otp[23:0] : 24'h0;
	assign sn_mid = state_reg.p1[dce_pkg::MODE_SERIAL] ? sn[39:8] : 32'h0;
	assign sn_hi  = state_reg.p1[dce_pkg::MODE_SERIAL] ? sn[55:40] : 16'h0;
	// extra bytes replace opcode and parameters for verify-only slots
	assign gd_params = state_reg.vo ? state_reg.extra
		: {state_reg.op, state_reg.p1, state_reg.p2[7:0], state_reg.p2[15:8]};

	always_comb begin
		if (!state_reg.keyed) begin
			msg_vec = {state_reg.key, gd_params, sn[7:0], sn[71:56], 200'h0, state_reg.scratch};
		end else if (!state_reg.outer) begin
			msg_vec = {256'h0, state_reg.scratch, state_reg.op, state_reg.p1, state_reg.p2[7:0],
				state_reg.p2[15:8], otp_lo, otp_hi, sn[7:0], sn_mid, sn[71:56], sn_hi, 64'h0};
		end else begin
			msg_vec = {state_reg.inner, 512'h0};
		end
	end

	assign key_vec = {state_reg.key, 256'h0}
		^ {64{state_reg.outer ? dce_pkg::OPAD : dce_pkg::IPAD}};
	assign total   = !state_reg.keyed ? dce_pkg::TOTAL_SHORT
		: (state_reg.outer ? dce_pkg::TOTAL_SHORT : dce_pkg::TOTAL_INNER);
	assign in_key  = state_reg.keyed && (state_reg.cnt < dce_pkg::KEY_BLOCK_LEN);
	assign midx    = state_reg.keyed ? state_reg.cnt - dce_pkg::KEY_BLOCK_LEN : state_reg.cnt;

	always_comb begin
		if (in_key) begin
			HASH_BYTE_O = key_vec[511 - 8*int'(state_reg.cnt) -: 8];
		end else begin
			HASH_BYTE_O = msg_vec[767 - 8*int'(midx) -: 8];
		end
	end

	// ---------------------------------------------------------------
	// handshake outputs
	// ---------------------------------------------------------------
	assign CMD_READY_O  = (state_reg.st == dce_pkg::ST_IDLE);
	assign MEM_REQ_O    = (state_reg.st == dce_pkg::ST_FETCH);
	assign HASH_INIT_O  = (state_reg.st == dce_pkg::ST_INIT);
	assign HASH_VALID_O = (state_reg.st == dce_pkg::ST_STREAM);
	// core appends standard padding after the final byte
	assign HASH_FINAL_O = (state_reg.st == dce_pkg::ST_FINAL);
	assign RDATA_O      = state_reg.rdata;
	assign RESP_VALID_O = state_reg.resp_valid;
	assign RESP_ERROR_O = state_reg.resp_err;
	assign RESP_LEN_O   = state_reg.resp_len;
	assign RESP_DATA_O  = state_reg.resp_data;

	always_comb begin
		if (!state_reg.keyed && state_reg.p1 == dce_pkg::ZONE_CONFIG) begin
			MEM_ZONE_O = dce_pkg::MEM_ZONE_CONFIG;
		end else if (!state_reg.keyed && state_reg.p1 == dce_pkg::ZONE_OTP) begin
			MEM_ZONE_O = dce_pkg::MEM_ZONE_OTP;
		end else if (!state_reg.keyed && state_reg.p2 >= dce_pkg::TRANSPORT_BASE) begin
			MEM_ZONE_O = dce_pkg::MEM_ZONE_TRANSPORT;
		end else begin
			MEM_ZONE_O = dce_pkg::MEM_ZONE_DATA;
		end
	end

	// slot number from the low four bits; transport keys keep the full selector
	assign MEM_INDEX_O = (MEM_ZONE_O == dce_pkg::MEM_ZONE_TRANSPORT) ? state_reg.p2
		: {12'h0, state_reg.p2[3:0]};

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic bad;
		logic vo_slot;
		bad     = 1'b0;
		vo_slot = 1'b0;
		state_next            = state_reg;
		state_next.resp_valid = 1'b0;
		state_next.rdata      = 32'h0;

		// bus clears first so an engine set in the same cycle wins
		if (WR_I && ADDR_I == ADDR_W'(dce_pkg::REG_CTRL) && WDATA_I[dce_pkg::CTRL_CLR_VALID]) begin
			state_next.valid = 1'b0;
		end

		case (state_reg.st)
			dce_pkg::ST_IDLE: begin
				if (CMD_VALID_I) begin
					state_next.op    = CMD_OPCODE_I;
					state_next.p1    = CMD_PARAM1_I;
					state_next.p2    = CMD_PARAM2_I;
					state_next.extra = CMD_DATA_I;
					state_next.keyed = 1'b0;
					state_next.outer = 1'b0;
					state_next.cnt   = 8'h0;
					state_next.valid = 1'b0;
					vo_slot = (CMD_PARAM1_I == dce_pkg::ZONE_DATA) && (CMD_PARAM2_I < dce_pkg::TRANSPORT_BASE)
						&& SLOT_VERIFY_ONLY_I[CMD_PARAM2_I[3:0]];
					state_next.vo = vo_slot;
					if (CMD_OPCODE_I == dce_pkg::OP_REVISION_QUERY) begin
						bad = (CMD_PARAM1_I != 8'h0) || (CMD_PARAM2_I != 16'h0);
						state_next.resp_valid = 1'b1;
						state_next.resp_err   = bad;
						state_next.resp_len   = bad ? dce_pkg::LEN_STATUS : dce_pkg::LEN_REVISION;
						state_next.resp_data  = bad ? {248'h0, dce_pkg::RES_PARSE_ERR} : {224'h0, REV_WORD};
					end else if (CMD_OPCODE_I == dce_pkg::OP_DIGEST_GENERATE) begin
						if (CMD_PARAM1_I > dce_pkg::ZONE_DATA
							|| (CMD_PARAM1_I != dce_pkg::ZONE_DATA && CMD_PARAM2_I > dce_pkg::BLOCK_SEL_MAX)
							|| (vo_slot && CMD_DATA_LEN_I != dce_pkg::LEN_EXTRA)) begin
							state_next.resp_valid = 1'b1;
							state_next.resp_err   = 1'b1;
							state_next.resp_len   = dce_pkg::LEN_STATUS;
							state_next.resp_data  = {248'h0, dce_pkg::RES_PARSE_ERR};
						end else if (!state_reg.valid
							|| (CMD_PARAM1_I == dce_pkg::ZONE_CONFIG && !CFG_LOCKED_I)) begin
							state_next.resp_valid = 1'b1;
							state_next.resp_err   = 1'b1;
							state_next.resp_len   = dce_pkg::LEN_STATUS;
							state_next.resp_data  = {248'h0, dce_pkg::RES_EXEC_ERR};
						end else begin
							state_next.st = dce_pkg::ST_FETCH;
						end
					end else if (CMD_OPCODE_I == dce_pkg::OP_KEYED_HASH) begin
						state_next.keyed = 1'b1;
						state_next.vo    = 1'b0;
						if ((CMD_PARAM1_I & dce_pkg::MODE_ZERO_MASK) != 8'h0
							|| CMD_DATA_LEN_I != 6'h0
							|| CMD_PARAM1_I[dce_pkg::MODE_NONCE] != state_reg.nonce_origin
							|| !state_reg.valid) begin
							state_next.resp_valid = 1'b1;
							state_next.resp_err   = 1'b1;
							state_next.resp_len   = dce_pkg::LEN_STATUS;
							state_next.resp_data  = {248'h0, dce_pkg::RES_EXEC_ERR};
						end else begin
							state_next.st = dce_pkg::ST_FETCH;
						end
					end else begin
						state_next.resp_valid = 1'b1;
						state_next.resp_err   = 1'b1;
						state_next.resp_len   = dce_pkg::LEN_STATUS;
						state_next.resp_data  = {248'h0, dce_pkg::RES_PARSE_ERR};
					end
				end
			end
			dce_pkg::ST_FETCH: begin
				if (MEM_ACK_I) begin
					state_next.key = MEM_DATA_I;
					state_next.st  = dce_pkg::ST_INIT;
				end
			end
			dce_pkg::ST_INIT: begin
				state_next.cnt = 8'h0;
				state_next.st  = dce_pkg::ST_STREAM;
			end
			dce_pkg::ST_STREAM: begin
				if (HASH_READY_I) begin
					state_next.cnt = state_reg.cnt + 8'h1;
					if (state_reg.cnt == total - 8'h1) begin
						state_next.st = dce_pkg::ST_FINAL;
					end
				end
			end
			dce_pkg::ST_FINAL: begin
				state_next.st = dce_pkg::ST_WAIT;
			end
			dce_pkg::ST_WAIT: begin
				if (HASH_DONE_I) begin
					if (state_reg.keyed && !state_reg.outer) begin
						state_next.inner = HASH_DIGEST_I;
						state_next.outer = 1'b1;
						state_next.st    = dce_pkg::ST_INIT;
					end else if (state_reg.keyed) begin
						state_next.resp_valid = 1'b1;
						state_next.resp_err   = 1'b0;
						state_next.resp_len   = dce_pkg::LEN_DIGEST;
						state_next.resp_data  = HASH_DIGEST_I;
						state_next.st         = dce_pkg::ST_IDLE;
					end else begin
						// digest stays inside; only a status byte goes out
						state_next.scratch     = HASH_DIGEST_I;
						state_next.valid       = 1'b1;
						state_next.data_origin = (state_reg.p1 == dce_pkg::ZONE_DATA)
							&& (state_reg.p2 <= dce_pkg::SLOT_TAG_MAX);
						if (state_reg.p1 == dce_pkg::ZONE_DATA && state_reg.p2 <= dce_pkg::SLOT_TAG_MAX) begin
							state_next.slot_tag = state_reg.p2[3:0];
						end
						state_next.resp_valid = 1'b1;
						state_next.resp_err   = 1'b0;
						state_next.resp_len   = dce_pkg::LEN_STATUS;
						state_next.resp_data  = {248'h0, dce_pkg::RES_OK};
						state_next.st         = dce_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				state_next.st = dce_pkg::ST_IDLE;
			end
		endcase

		// register port; scratch digest words are write-only
		if (WR_I) begin
			if (ADDR_I == ADDR_W'(dce_pkg::REG_CTRL)) begin
				state_next.nonce_origin = WDATA_I[dce_pkg::CTRL_NONCE_FLAG];
				if (WDATA_I[dce_pkg::CTRL_SET_VALID]) begin
					state_next.valid = 1'b1;
				end
			end
			for (int k = 0; k < 8; k++) begin
				if (ADDR_I == ADDR_W'(dce_pkg::REG_DIGEST0 + 8'(4*k))) begin
					state_next.scratch[255-32*k -: 32] = WDATA_I;
				end
			end
		end
		if (RD_I) begin
			if (ADDR_I == ADDR_W'(dce_pkg::REG_STATUS)) begin
				state_next.rdata[dce_pkg::STAT_VALID]       = state_reg.valid;
				state_next.rdata[dce_pkg::STAT_DATA_ORIGIN] = state_reg.data_origin;
				state_next.rdata[dce_pkg::STAT_NONCE]       = state_reg.nonce_origin;
				state_next.rdata[dce_pkg::STAT_BUSY]        = (state_reg.st != dce_pkg::ST_IDLE);
				state_next.rdata[dce_pkg::STAT_TAG_LSB +: 4] = state_reg.slot_tag;
			end else if (ADDR_I == ADDR_W'(dce_pkg::REG_CTRL)) begin
				state_next.rdata[dce_pkg::CTRL_NONCE_FLAG] = state_reg.nonce_origin;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state_reg    <= '0;
			state_reg.st <= dce_pkg::ST_IDLE;
		end else if (CE_I) begin
			state_reg <= state_next;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I || !CE_I);

	a_rev_answer: assert property (
		RESP_VALID_O && !RESP_ERROR_O && state_reg.op == dce_pkg::OP_REVISION_QUERY
		|-> RESP_LEN_O == 6'h04 && RESP_DATA_O[31:0] == REV_WORD)
		else $error("revision answer wrong");
	a_digest_writeback: assert property (
		state_reg.st == dce_pkg::ST_WAIT && HASH_DONE_I && !state_reg.keyed
		|=> state_reg.scratch == $past(HASH_DIGEST_I) && state_reg.valid && RESP_VALID_O)
		else $error("scratch digest not written back");
	a_origin_flag: assert property (
		state_reg.st == dce_pkg::ST_WAIT && HASH_DONE_I && !state_reg.keyed
		|=> state_reg.data_origin == (state_reg.p1 == 8'h02 && state_reg.p2 <= 16'h000f))
		else $error("data origin flag wrong");
	a_no_digest_out: assert property (
		RESP_VALID_O && state_reg.op == dce_pkg::OP_DIGEST_GENERATE |-> RESP_LEN_O == 6'h01
		&& RESP_DATA_O[255:8] == 248'h0)
		else $error("digest generate returned more than status");
	a_invalid_reject: assert property (
		CMD_READY_O && CMD_VALID_I && CMD_OPCODE_I == 8'h15 && !state_reg.valid
		|=> RESP_VALID_O && RESP_ERROR_O && state_reg.st == dce_pkg::ST_IDLE)
		else $error("invalid scratch digest accepted");
	a_valid_cleared: assert property (
		CMD_READY_O && CMD_VALID_I && !(WR_I && WDATA_I[0]) |=> !state_reg.valid)
		else $error("valid flag kept after new command");
	a_cfg_locked: assert property (
		CMD_READY_O && CMD_VALID_I && CMD_OPCODE_I == 8'h15 && CMD_PARAM1_I == 8'h00 && !CFG_LOCKED_I
		|=> RESP_VALID_O && RESP_ERROR_O)
		else $error("unlocked config zone accepted");
	a_slot_select: assert property (
		MEM_REQ_O && state_reg.p1 == 8'h02 && state_reg.p2 < 16'h8000
		|-> MEM_ZONE_O == 2'h2 && MEM_INDEX_O == {12'h0, state_reg.p2[3:0]})
		else $error("slot index wrong");
	a_extra_bytes: assert property (
		HASH_VALID_O && !state_reg.keyed && state_reg.vo && state_reg.cnt == 8'd32
		|-> HASH_BYTE_O == state_reg.extra[31:24])
		else $error("extra input byte not hashed");
	a_hmac_length: assert property (
		state_reg.st == dce_pkg::ST_WAIT && HASH_DONE_I && state_reg.keyed && state_reg.outer
		|=> RESP_VALID_O && RESP_LEN_O == 6'h20 && RESP_DATA_O == $past(HASH_DIGEST_I))
		else $error("keyed hash response wrong");
	a_mode_nonce: assert property (
		CMD_READY_O && CMD_VALID_I && CMD_OPCODE_I == 8'h11 && CMD_PARAM1_I[2] != state_reg.nonce_origin
		|=> RESP_VALID_O && RESP_ERROR_O)
		else $error("nonce mode mismatch accepted");

endmodule

// ===== sim/dce_far_model.sv
`timescale 1ns/1ps
module dce_far_model #(
	parameter logic [255:0] BLK = {8{32'h1234abcd}},
	parameter logic [255:0] DIG = {8{32'h5a0f3cc3}}
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         mem_req_i,
	input  wire logic [1:0]   mem_zone_i,
	input  wire logic [15:0]  mem_index_i,
	output logic              mem_ack_o,
	output logic      [255:0] mem_data_o,
	input  wire logic         hash_init_i,
	input  wire logic         hash_valid_i,
	input  wire logic [7:0]   hash_byte_i,
	output logic              hash_ready_o,
	input  wire logic         hash_final_i,
	output logic              hash_done_o,
	output logic      [255:0] hash_digest_o
);
	logic [7:0]  msg [0:255];
	int          n;
	logic [1:0]  zone_seen;
	logic [15:0] idx_seen;
	logic [3:0]  cyc;
	logic        pend;
	// released lines show the inverse, never a stale value
	assign mem_data_o    = mem_ack_o ? BLK : ~BLK;
	assign hash_digest_o = hash_done_o ? DIG : ~DIG;
	always @(posedge clk_i) begin
		cyc <= cyc + 4'h1;
		mem_ack_o <= mem_req_i && !mem_ack_o && cyc[1];
		if (mem_req_i) begin
			zone_seen <= mem_zone_i;
			idx_seen  <= mem_index_i;
		end
		// ready drops now and then, so the engine must hold a byte
		hash_ready_o <= cyc[0] | cyc[2];
		if (hash_init_i) begin
			n <= 0;
		end else if (hash_valid_i && hash_ready_o) begin
			msg[n] <= hash_byte_i;
			n      <= n + 1;
		end
		pend        <= hash_final_i;
		hash_done_o <= pend;
		if (rst_i) begin
			cyc         <= 4'h0;
			mem_ack_o   <= 1'b0;
			pend        <= 1'b0;
			hash_done_o <= 1'b0;
			n           <= 0;
		end
	end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0]  REV = 32'h0000a5c3; // arbitrary value
	localparam logic [255:0] BLK = {8{32'h1234abcd}};
	localparam logic [255:0] DIG = {8{32'h5a0f3cc3}};
	localparam logic [71:0]  SN  = 72'h998877665544332211;
	logic clk = 0, rst = 1, wr = 0, rd = 0, cv = 0, lk = 0;
	logic [7:0] adr = 8'h00, op = 8'h00, p1 = 8'h00;
	logic [15:0] p2 = 16'h0000, vo = 16'h0000;
	logic [31:0] wd = 32'h0, cd = 32'h0, rdat, v;
	logic [5:0] cl = 6'h0, rlen;
	logic rv, rerr, crdy, mreq, mack, hi, hv, hr, hf, hd;
	logic [255:0] rdata, mdat, hdig;
	logic [1:0] mz;
	logic [15:0] mi;
	logic [7:0] hb;
	int bad_count = 0, comparisons = 0;
	always #50 clk = ~clk;
	dce_engine #(.REV_WORD(REV)) u_dce_engine (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(1'b1),
		.ADDR_I(adr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .CMD_VALID_I(cv),
		.CMD_READY_O(crdy), .CMD_OPCODE_I(op), .CMD_PARAM1_I(p1), .CMD_PARAM2_I(p2), .CMD_DATA_I(cd),
		.CMD_DATA_LEN_I(cl), .RESP_VALID_O(rv), .RESP_ERROR_O(rerr), .RESP_LEN_O(rlen), .RESP_DATA_O(rdata),
		.MEM_REQ_O(mreq), .MEM_ZONE_O(mz), .MEM_INDEX_O(mi), .MEM_ACK_I(mack), .MEM_DATA_I(mdat),
		.SLOT_VERIFY_ONLY_I(vo), .CFG_LOCKED_I(lk), .SERIAL_I(SN), .OTP_HEAD_I(88'h0a0908070605040302010f),
		.HASH_INIT_O(hi), .HASH_VALID_O(hv), .HASH_BYTE_O(hb), .HASH_READY_I(hr), .HASH_FINAL_O(hf),
		.HASH_DONE_I(hd), .HASH_DIGEST_I(hdig));
	dce_far_model #(.BLK(BLK), .DIG(DIG)) u_dce_far_model (.clk_i(clk), .rst_i(rst), .mem_req_i(mreq),
		.mem_zone_i(mz), .mem_index_i(mi), .mem_ack_o(mack), .mem_data_o(mdat), .hash_init_i(hi),
		.hash_valid_i(hv), .hash_byte_i(hb), .hash_ready_o(hr), .hash_final_i(hf), .hash_done_o(hd),
		.hash_digest_o(hdig));
	task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr  <= 1'b1;
		adr <= a;
		wd  <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		rd  <= 1'b1;
		adr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdat;
	endtask
	// one command, result captured in the single cycle it stands
	task automatic cmd(input logic [7:0] o, input logic [7:0] a, input logic [15:0] b,
		input logic [31:0] d, input logic [5:0] l);
		int i;
		@(posedge clk);
		cv <= 1'b1;
		op <= o;
		p1 <= a;
		p2 <= b;
		cd <= d;
		cl <= l;
		@(posedge clk);
		cv <= 1'b0;
		#1;
		for (i = 0; i < 3000 && rv !== 1'b1; i++) @(posedge clk) #1;
		chk(rv, 1'b1);
	endtask
	task automatic summarize();
		if (bad_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		cmd(8'h30, 8'h00, 16'h0000, 32'h0, 6'h0);
		chk({rerr, rlen, rdata[31:0]}, {1'b0, 6'h04, REV});
		cmd(8'h30, 8'h01, 16'h0000, 32'h0, 6'h0);
		chk({rerr, rdata[7:0]}, {1'b1, 8'h03});
		cmd(8'h15, 8'h02, 16'h0003, 32'h0, 6'h0);
		chk({rerr, rdata[7:0]}, {1'b1, 8'h0f});
		wreg(8'h04, 32'h1);
		cmd(8'h15, 8'h02, 16'h0003, 32'h0, 6'h0);
		chk({rerr, rlen, rdata[7:0]}, {1'b0, 6'h01, 8'h00});
		chk({u_dce_far_model.zone_seen, u_dce_far_model.idx_seen}, {2'h2, 16'h0003});
		chk(u_dce_far_model.n, 96);
		chk({u_dce_far_model.msg[0], u_dce_far_model.msg[32], u_dce_far_model.msg[33]},
			{BLK[255:248], 8'h15, 8'h02});
		chk({u_dce_far_model.msg[36], u_dce_far_model.msg[37], u_dce_far_model.msg[39]},
			{SN[71:64], SN[7:0], 8'h00});
		rreg(8'h00);
		chk(v[7:0], 8'h33);
		cmd(8'h15, 8'h02, 16'h8001, 32'h0, 6'h0);
		chk({u_dce_far_model.zone_seen, u_dce_far_model.msg[34], u_dce_far_model.msg[35]},
			{2'h3, 8'h01, 8'h80});
		rreg(8'h00);
		chk(v[1:0], 2'h1);
		vo <= 16'h0020;
		cmd(8'h15, 8'h02, 16'h0005, 32'hdeadbeef, 6'h04);
		chk({u_dce_far_model.msg[32], u_dce_far_model.msg[35], u_dce_far_model.msg[36]},
			{8'hde, 8'hef, SN[71:64]});
		cmd(8'h15, 8'h01, 16'h0001, 32'h0, 6'h0);
		chk({u_dce_far_model.zone_seen, u_dce_far_model.idx_seen, rerr}, {2'h1, 16'h0001, 1'b0});
		cmd(8'h15, 8'h00, 16'h0000, 32'h0, 6'h0);
		chk({rerr, rdata[7:0]}, {1'b1, 8'h0f});
		rreg(8'h00);
		chk(v[0], 1'b0);
		wreg(8'h04, 32'h1);
		cmd(8'h11, 8'h01, 16'h0002, 32'h0, 6'h0);
		chk({rerr, rdata[7:0]}, {1'b1, 8'h0f});
		wreg(8'h04, 32'h1);
		cmd(8'h11, 8'h44, 16'h0002, 32'h0, 6'h0);
		chk({rerr, rdata[7:0]}, {1'b1, 8'h0f});
		wreg(8'h04, 32'h1);
		cmd(8'h11, 8'h40, 16'h1002, 32'h0, 6'h0);
		chk({rerr, rlen, rdata}, {1'b0, 6'h20, DIG});
		chk(u_dce_far_model.idx_seen[3:0], 4'h2);
		chk({u_dce_far_model.n, u_dce_far_model.msg[64]}, {32'd96, DIG[255:248]});
		summarize();
	end
endmodule
